//--- rtl/iqf_defs.svh
// constants of the (i,q) pulse stream framer
//
// Notes on behaviour
// - each pulse sends new-pulse code, trigger code, burst pair, then receiver pairs.
// - receiver words flow until next pulse; short clearing gap precedes the restart.
// - new-pulse code is all zeros; every other word has its top bit set.
// - trigger code follows new-pulse: bit17 one, bits16..8 zero, flags/bank/waveform.
// - only defined trigger code encodings are ever emitted.
// - flags read 01 on the final pulse of a group forming the next ray.
// - bank is 000 normal, 001 low rate, 010 blanked, 111 noise measurement.
// - waveform 000 normal or first of sequence, 001 alternate pulse.
// - custom pattern waveform counts up over eight pulses, then holds 111.
// - sample word: bit17 set, exponent bits16..15, signed mantissa bits14..0.
// - sample value is mantissa times sixteen to the exponent, no hidden bit.
// - exponent chosen so mantissa is the largest fitting fifteen-bit integer.
// - with exponent zero the mantissa may be small, underflowing gracefully.
`ifndef IQF_DEFS_SVH
`define IQF_DEFS_SVH

// word layout
`define IQF_WORD_W        18
`define IQF_MARK_BIT      17
`define IQF_EXP_HI        16
`define IQF_EXP_LO        15
`define IQF_MAN_HI        14
`define IQF_MAN_W         15
`define IQF_EXP_MAX       2'h3
`define IQF_EXP_STEP      4

// fixed code words
`define IQF_NEW_PULSE     18'h00000
`define IQF_TRIG_BASE     18'h20000

// trigger code fields
`define IQF_FLAGS_POS     6
`define IQF_BANK_POS      3
`define IQF_WAVE_POS      0
`define IQF_FLAGS_LAST    2'h1
`define IQF_FLAGS_NONE    2'h0
`define IQF_BANK_NORMAL   3'h0
`define IQF_BANK_LOW_RATE 3'h1
`define IQF_BANK_BLANKED  3'h2
`define IQF_BANK_NOISE    3'h7
`define IQF_WAVE_NORMAL   3'h0
`define IQF_WAVE_ALT      3'h1
`define IQF_WAVE_HOLD     3'h7

// timing
`define IQF_CLOCK_NS      25
`define IQF_CLEAR_NS      150
`define IQF_CLEAR_CYCLES  ((`IQF_CLEAR_NS + `IQF_CLOCK_NS - 1) / `IQF_CLOCK_NS)

`endif

//--- rtl/iqf_pkg.sv
// types of the (i,q) pulse stream framer
package iqf_pkg;

	// pulse class as seen by the trigger logic
	typedef enum logic [1:0] {
		IQF_CLASS_NORMAL        = 2'h0,
		IQF_CLASS_LOW_RATE      = 2'h1,
		IQF_CLASS_BLANKED       = 2'h2,
		IQF_CLASS_NOISE_MEASURE = 2'h3
	} iqf_class_e;

	// framing sequence, one-hot
	typedef enum logic [7:0] {
		IQF_ST_IDLE    = 8'h01,
		IQF_ST_GAP     = 8'h02,
		IQF_ST_NEW     = 8'h04,
		IQF_ST_TRIG    = 8'h08,
		IQF_ST_BURST_I = 8'h10,
		IQF_ST_BURST_Q = 8'h20,
		IQF_ST_RX_I    = 8'h40,
		IQF_ST_RX_Q    = 8'h80
	} iqf_state_e;

	typedef logic [17:0] iqf_word_t;

	// state on the system clock
	typedef struct packed {
		iqf_state_e state;
		logic       pending;
		logic [7:0] gap_count;
		logic [2:0] pat_count;
		iqf_word_t  trig;
		iqf_word_t  burst_q;
		iqf_word_t  rx_q;
		iqf_word_t  word;
		logic       req;
		logic       ack_meta;
		logic       ack_sync;
	} iqf_sys_s;

	// state on the sample bus clock
	typedef struct packed {
		logic      req_meta;
		logic      req_sync;
		logic      req_seen;
		iqf_word_t bus;
		logic      valid;
	} iqf_link_s;

endpackage

//--- rtl/iqf_framer.sv
// (i,q) pulse stream framer: builds and sends per-pulse word sequences
`include "iqf_defs.svh"

module iqf_framer #(
	parameter int IN_W = 24
) (
	// system clock and reset
	input  wire logic                 i_clock,
	input  wire logic                 i_reset,
	// link clock
	input  wire logic                 i_sample_bus_clock,
	// pulse description, on the system clock
	input  wire logic                 i_pulse_start,
	input  wire logic                 i_last_in_group,
	input  wire iqf_pkg::iqf_class_e  i_pulse_class,
	input  wire logic                 i_alternate_pulse,
	input  wire logic                 i_custom_pattern,
	input  wire logic                 i_pattern_first,
	input  wire logic [IN_W-1:0]      i_burst_i,
	input  wire logic [IN_W-1:0]      i_burst_q,
	// receiver samples, on the system clock
	input  wire logic                 i_rx_valid,
	input  wire logic [IN_W-1:0]      i_rx_i,
	input  wire logic [IN_W-1:0]      i_rx_q,
	output logic                      o_rx_ready,
	// sample word bus, on the link clock
	output logic [`IQF_WORD_W-1:0]    o_sample_word_bus,
	output logic                      o_sample_word_valid
);
	import iqf_pkg::*;

	localparam logic [7:0] GAP_CYCLES = 8'(`IQF_CLEAR_CYCLES);

	iqf_sys_s  sys;
	iqf_sys_s  next_sys;
	iqf_link_s lnk;
	iqf_link_s next_lnk;

	iqf_word_t burst_i_word;
	iqf_word_t burst_q_word;
	iqf_word_t rx_i_word;
	iqf_word_t rx_q_word;
	logic      lnk_reset;

	// one packer per raw input: every word is ready in the cycle the
	// sequencer wants it, at the cost of four copies of the logic
	iqf_float_pack #(.IN_W(IN_W)) i_pack_burst_i (
		.i_raw  (i_burst_i),
		.o_word (burst_i_word)
	);
	iqf_float_pack #(.IN_W(IN_W)) i_pack_burst_q (
		.i_raw  (i_burst_q),
		.o_word (burst_q_word)
	);
	iqf_float_pack #(.IN_W(IN_W)) i_pack_rx_i (
		.i_raw  (i_rx_i),
		.o_word (rx_i_word)
	);
	iqf_float_pack #(.IN_W(IN_W)) i_pack_rx_q (
		.i_raw  (i_rx_q),
		.o_word (rx_q_word)
	);

	// trigger code; every field comes from a closed case, so no reserved
	// code can be formed
	function automatic iqf_word_t trig_pack(input logic [1:0] flags,
			input logic [2:0] bank, input logic [2:0] wave);
		trig_pack = `IQF_TRIG_BASE
			| (iqf_word_t'(flags) << `IQF_FLAGS_POS)
			| (iqf_word_t'(bank) << `IQF_BANK_POS)
			| (iqf_word_t'(wave) << `IQF_WAVE_POS);
	endfunction

	logic       busy;
	logic       load;
	iqf_word_t  load_word;
	logic [1:0] flags;
	logic [2:0] bank;
	logic [2:0] wave;
	logic [2:0] next_pat;

	// a word is in flight until the link side acknowledges it
	assign busy       = sys.req != sys.ack_sync;
	assign o_rx_ready = (sys.state == IQF_ST_RX_I) && !busy && !sys.pending;

	// descriptor fields of the pulse being announced
	always_comb begin
		flags = i_last_in_group ? `IQF_FLAGS_LAST : `IQF_FLAGS_NONE;
		unique case (i_pulse_class)
			IQF_CLASS_NORMAL:        bank = `IQF_BANK_NORMAL;
			IQF_CLASS_LOW_RATE:      bank = `IQF_BANK_LOW_RATE;
			IQF_CLASS_BLANKED:       bank = `IQF_BANK_BLANKED;
			IQF_CLASS_NOISE_MEASURE: bank = `IQF_BANK_NOISE;
		endcase
		// custom patterns count up, then hold the top code
		if (i_pattern_first) begin
			next_pat = `IQF_WAVE_NORMAL;
		end else if (sys.pat_count != `IQF_WAVE_HOLD) begin
			next_pat = sys.pat_count + 3'h1;
		end else begin
			next_pat = `IQF_WAVE_HOLD;
		end
		if (i_custom_pattern) begin
			wave = next_pat;
		end else if (i_alternate_pulse) begin
			wave = `IQF_WAVE_ALT;
		end else begin
			wave = `IQF_WAVE_NORMAL;
		end
	end

	// sequencer on the system clock
	always_comb begin
		next_sys          = sys;
		load              = 1'b0;
		load_word         = sys.word;
		next_sys.ack_meta = lnk.req_seen; // link toggle, first of two flops
		next_sys.ack_sync = sys.ack_meta;
		if (i_pulse_start) begin
			// descriptor and burst q word are caught when the pulse goes out; burst i is packed when it is sent
			next_sys.pending = 1'b1;
			next_sys.trig    = trig_pack(flags, bank, wave);
			next_sys.burst_q = burst_q_word;
			if (i_custom_pattern) begin
				next_sys.pat_count = next_pat;
			end
		end
		unique case (sys.state)
			IQF_ST_IDLE: begin
				if (sys.pending) begin
					next_sys.state     = IQF_ST_GAP;
					next_sys.gap_count = GAP_CYCLES;
				end
			end
			IQF_ST_GAP: begin
				// clearing gap of about one range bin before the restart
				if (sys.gap_count > 8'h1) begin
					next_sys.gap_count = sys.gap_count - 8'h1;
				end else begin
					next_sys.state = IQF_ST_NEW;
				end
			end
			IQF_ST_NEW: begin
				if (!busy) begin
					load             = 1'b1;
					load_word        = `IQF_NEW_PULSE;
					next_sys.pending = i_pulse_start;
					next_sys.state   = IQF_ST_TRIG;
				end
			end
			IQF_ST_TRIG: begin
				if (!busy) begin
					load           = 1'b1;
					load_word      = sys.trig;
					next_sys.state = IQF_ST_BURST_I;
				end
			end
			IQF_ST_BURST_I: begin
				if (!busy) begin
					load           = 1'b1;
					load_word      = burst_i_word;
					next_sys.state = IQF_ST_BURST_Q;
				end
			end
			IQF_ST_BURST_Q: begin
				if (!busy) begin
					load           = 1'b1;
					load_word      = sys.burst_q;
					next_sys.state = IQF_ST_RX_I;
				end
			end
			IQF_ST_RX_I: begin
				// a new pulse cuts the stream only between pairs
				if (!busy && sys.pending) begin
					next_sys.state     = IQF_ST_GAP;
					next_sys.gap_count = GAP_CYCLES;
				end else if (!busy && i_rx_valid) begin
					load           = 1'b1;
					load_word      = rx_i_word;
					next_sys.rx_q  = rx_q_word;
					next_sys.state = IQF_ST_RX_Q;
				end
			end
			IQF_ST_RX_Q: begin
				if (!busy) begin
					load           = 1'b1;
					load_word      = sys.rx_q;
					next_sys.state = IQF_ST_RX_I;
				end
			end
			// an illegal code falls back to idle rather than locking up
			default: begin
				next_sys.state = IQF_ST_IDLE;
			end
		endcase
		if (load) begin
			next_sys.word = load_word;
			next_sys.req  = !sys.req;
		end
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			sys <= '{state: IQF_ST_IDLE, pending: 1'b0, gap_count: 8'h00,
				pat_count: `IQF_WAVE_HOLD, trig: 18'h00000,
				burst_q: 18'h00000, rx_q: 18'h00000, word: 18'h00000,
				req: 1'b0, ack_meta: 1'b0, ack_sync: 1'b0};
		end else begin
			sys <= next_sys;
		end
	end

	// link side: the word register in the system domain stays still while
	// the request toggle is unacknowledged, so it is safe to sample here
	always_comb begin
		next_lnk          = lnk;
		next_lnk.req_meta = sys.req;
		next_lnk.req_sync = lnk.req_meta;
		next_lnk.req_seen = lnk.req_sync;
		next_lnk.valid    = lnk.req_sync != lnk.req_seen;
		if (lnk.req_sync != lnk.req_seen) begin
			next_lnk.bus = sys.word;
		end
	end

	// link side leaves reset on its own clock, never close to its edges
	iqf_reset_sync i_lnk_reset (
		.i_clock (i_sample_bus_clock),
		.i_reset (i_reset),
		.o_reset (lnk_reset)
	);

	always_ff @(posedge i_sample_bus_clock or posedge lnk_reset) begin
		if (lnk_reset) begin
			lnk <= '{req_meta: 1'b0, req_sync: 1'b0, req_seen: 1'b0,
				bus: 18'h20000, valid: 1'b0};
		end else begin
			lnk <= next_lnk;
		end
	end

	// bus changes just after a rising edge and holds a full period,
	// so the far end may latch on either edge
	assign o_sample_word_bus   = lnk.bus;
	assign o_sample_word_valid = lnk.valid;

endmodule

// block floating point packer: the smallest exponent whose shifted value
// still fits fifteen bits keeps the most relative precision
module iqf_float_pack #(
	parameter int IN_W = 24
) (
	// raw signed sample
	input  wire logic [IN_W-1:0] i_raw,
	// packed sample word
	output iqf_pkg::iqf_word_t   o_word
);
	import iqf_pkg::*;

	logic signed [IN_W-1:0] shifted;
	logic [IN_W-1:0]        top;
	logic [1:0]             exp;
	logic [IN_W-1:0]        best;

	// widest shift first; each narrower one that still fits takes over;
	// inputs wider than 27 bits would need a larger exponent field
	always_comb begin
		exp     = `IQF_EXP_MAX;
		best    = IN_W'($signed(i_raw) >>> (`IQF_EXP_STEP * 3));
		shifted = '0;
		top     = '0;
		for (int e = 3; e >= 0; e--) begin
			shifted = $signed(i_raw) >>> (`IQF_EXP_STEP * e);
			top     = IN_W'(shifted) >> (`IQF_MAN_W - 1);
			if ((&top[IN_W-`IQF_MAN_W:0]) || !(|top[IN_W-`IQF_MAN_W:0])) begin
				exp  = 2'(e);
				best = IN_W'(shifted);
			end
		end
		// mantissa times sixteen to the exponent, no hidden bit
		o_word = {1'b1, exp, best[`IQF_MAN_W-1:0]};
	end

endmodule

// reset release for the link side: asserts at once, but lets go only on
// a link clock edge; the first stage is read by the second alone
module iqf_reset_sync (
	// link clock and raw reset
	input  wire logic i_clock,
	input  wire logic i_reset,
	// reset for the link side
	output logic      o_reset
);
	logic [1:0] stage;
	logic [1:0] next_stage;

	// zeros shift in behind the release
	always_comb begin
		next_stage = {stage[0], 1'b0};
	end

	always_ff @(posedge i_clock or posedge i_reset) begin
		if (i_reset) begin
			stage <= 2'h3;
		end else begin
			stage <= next_stage;
		end
	end

	assign o_reset = stage[1];

endmodule

//--- testbench/iqf_capture.sv
// partner model: data processor tapping the sample word bus
module iqf_capture (
	// link clock and bus
	input  wire logic        i_sample_bus_clock,
	input  wire logic        i_valid,
	input  wire logic [17:0] i_bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [17:0] q[$];

	// rising edge latch, it leaves the widest setup margin
	always @(posedge i_sample_bus_clock) begin
		if (i_valid)
			q.push_back(i_bus);
	end
endmodule

//--- testbench/iqf_framer_properties.sv
// checker of the sample word bus and receiver handshake
module iqf_chk (
	// clocks and reset
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic        i_sample_bus_clock,
	// watched ports
	input  wire logic        i_pulse_start,
	input  wire logic        o_rx_ready,
	input  wire logic [17:0] o_sample_word_bus,
	input  wire logic        o_sample_word_valid
);
	wire logic        v = o_sample_word_valid;
	wire logic [17:0] w = o_sample_word_bus;
	logic [17:0]      prev;
	logic [7:0]       cnt;
	logic             seen;

	// last word and count of words since the new-pulse code
	always_ff @(posedge i_sample_bus_clock or posedge i_reset) begin
		if (i_reset) begin
			prev <= 18'h20000;
			cnt  <= 8'h0;
			seen <= 1'b0;
		end else if (v) begin
			prev <= w;
			cnt  <= (w == 18'h0) ? 8'h0 : cnt + 8'h1;
			seen <= seen | (w == 18'h0);
		end
	end

	a_top_bit: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) v && w != 18'h0 |-> w[17])
		else $error("word with top bit clear");
	a_trig_layout: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) v && seen && prev == 18'h0 |-> w[17:8] == 10'h200)
		else $error("bad trigger code layout");
	a_bank_known: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) v && seen && prev == 18'h0
		|-> w[5:3] inside {3'h0, 3'h1, 3'h2, 3'h7})
		else $error("reserved bank code");
	a_flags_known: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) v && seen && prev == 18'h0 |-> !w[7])
		else $error("reserved flags code");
	a_man_normal: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) v && seen && prev != 18'h0 && w != 18'h0
		&& w[16:15] != 2'h0 |-> !(w[14:10] inside {5'h0, 5'h1f}))
		else $error("mantissa not normalised");
	a_whole_pairs: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) v && w == 18'h0 && seen |-> cnt[0])
		else $error("incomplete pair before new pulse");
	a_valid_once: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) v |=> !v)
		else $error("valid longer than one cycle");
	a_bus_holds: assert property (@(posedge i_sample_bus_clock)
		disable iff (i_reset) !v |-> $stable(w))
		else $error("bus changed without valid");
	a_gap_quiet: assert property (@(posedge i_clock)
		disable iff (i_reset) i_pulse_start |=> !o_rx_ready [*6])
		else $error("receiver taken during clearing gap");
endmodule

bind iqf_framer iqf_chk i_chk (.i_clock(i_clock), .i_reset(i_reset),
	.i_sample_bus_clock(i_sample_bus_clock), .i_pulse_start(i_pulse_start),
	.o_rx_ready(o_rx_ready), .o_sample_word_bus(o_sample_word_bus),
	.o_sample_word_valid(o_sample_word_valid));

//--- testbench/iqf_pulse_stream_framer_tb_top.sv
// self-checking bench of the framer with a capturing partner
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
	n_fail++; $display("BAD %s exp %h got %h", n, e, s); end end

module iqf_pulse_stream_framer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import iqf_pkg::*;
	logic        clk, rst, lclk, ps, last, alt, cust, first, rxv, rdy, ov;
	iqf_class_e  cls;
	logic [23:0] bi, bq, ri, rq;
	logic [17:0] ob;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	iqf_framer #(.IN_W(24)) i_dut (.i_clock(clk), .i_reset(rst),
		.i_sample_bus_clock(lclk), .i_pulse_start(ps),
		.i_last_in_group(last), .i_pulse_class(cls),
		.i_alternate_pulse(alt), .i_custom_pattern(cust),
		.i_pattern_first(first), .i_burst_i(bi), .i_burst_q(bq),
		.i_rx_valid(rxv), .i_rx_i(ri), .i_rx_q(rq), .o_rx_ready(rdy),
		.o_sample_word_bus(ob), .o_sample_word_valid(ov));
	iqf_capture i_cap (.i_sample_bus_clock(lclk), .i_valid(ov), .i_bus(ob));

	// system clock and an unrelated link clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#3;
		forever #6 lclk = ~lclk;
	end

	// expected word: value is mantissa times 16 to the exponent
	function automatic logic [17:0] enc(input logic signed [23:0] v);
		int e;
		logic signed [23:0] m;
		e = 0;
		m = v;
		while (e < 3 && (m > 16383 || m < -16384)) begin
			e++;
			m = v >>> (4 * e);
		end
		return {1'b1, e[1:0], m[14:0]};
	endfunction

	task automatic test_done();
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			test_done();
		end
	end

	// one pulse, one receiver pair, then the six words it must yield
	task automatic run(input logic [7:0] code, input logic l, a, c, f,
		input iqf_class_e k, input logic [23:0] b0, b1, r0, r1);
		logic [17:0] ex[6];
		ex = '{18'h0, 18'h20000 | code, enc(b0), enc(b1), enc(r0), enc(r1)};
		@(posedge clk);
		{last, alt, cust, first} <= {l, a, c, f};
		{bi, bq, ri, rq} <= {b0, b1, r0, r1};
		cls <= k;
		ps <= 1'b1;
		@(posedge clk);
		ps <= 1'b0;
		rxv <= 1'b1;
		// pair is taken at the rising edge after ready is seen high at a falling edge
		@(negedge clk);
		while (rdy !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		rxv <= 1'b0;
		while (i_cap.q.size() < 6)
			@(posedge clk);
		foreach (ex[j]) `CHK("word", ex[j], i_cap.q[j])
		i_cap.q.delete();
	endtask

	// last pulse of a ray with exponent boundary values
	task automatic t_basic();
		run(8'h40, 1'b1, 1'b0, 1'b0, 1'b0, IQF_CLASS_NORMAL, 24'd5, 24'hffc000,
			24'h400000, 24'd16384);
	endtask

	// every bank code, alternate waveform on odd classes
	task automatic t_classes();
		logic [2:0] bk[4];
		bk = '{3'h0, 3'h1, 3'h2, 3'h7};
		for (int i = 0; i < 4; i++)
			run({2'h0, bk[i], 3'(i % 2)}, 1'b0, i[0], 1'b0, 1'b0,
				iqf_class_e'(i), 24'h100000, 24'd16383, 24'hffffff,
				24'h7ff000);
	endtask

	// custom pattern longer than eight pulses holds the top code
	task automatic t_custom();
		for (int i = 0; i < 9; i++)
			run({5'h0, 3'(i < 8 ? i : 7)}, 1'b0, 1'b0, 1'b1, i == 0,
				IQF_CLASS_NORMAL, 24'd1, 24'd2, 24'd3, 24'd4);
	endtask

	initial begin
		rst = 1'b1;
		{ps, last, alt, cust, first, rxv, bi, bq, ri, rq} = '0;
		cls = IQF_CLASS_NORMAL;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_basic();
		t_classes();
		t_custom();
		test_done();
	end
endmodule
